// [verilog/mmdec_defs.vh]
// Purpose: constants for the memory map decoder
// Assumes: byte-wide register file and program memory
// Notes: addresses are byte addresses
`ifndef MMDEC_DEFS_VH
`define MMDEC_DEFS_VH
`define MMDEC_RF_AW 12
`define MMDEC_RF_CTL_BASE 12'hF00
`define MMDEC_RAM_TOP 12'h0FF
`define MMDEC_PM_AW 16
`define MMDEC_INFO_BASE 16'hFE00
`define MMDEC_INFO_LAST 16'hFE7F
`define MMDEC_INFO_EN_BIT 7
`define MMDEC_PM_ABSENT 8'hFF
`define MMDEC_RF_UNDEF 8'h00
`define MMDEC_OPT_LAST 16'h0001
`define MMDEC_RSTV_LAST 16'h0003
`define MMDEC_IVEC_LAST 16'h003D
`define MMDEC_ID_BASE 16'hFE40
`define MMDEC_ID_LAST 16'hFE53
`define MMDEC_CAL_BASE 16'hFE60
`define MMDEC_REGION_OPT 2'h0
`define MMDEC_REGION_RSTV 2'h1
`define MMDEC_REGION_IVEC 2'h2
`define MMDEC_REGION_CODE 2'h3
`define MMDEC_INFO_FILL 8'hFF
`endif

// [verilog/mmdec_ram.v]
// Purpose: byte RAM with registered read
// Assumes: one access per cycle
// Notes: contents are not reset
`default_nettype none
module mmdec_ram #(
	parameter AW = 8
) (
	input wire sys_clk,
	input wire we,
	input wire [AW-1:0] addr,
	input wire [7:0] wdata,
	output reg [7:0] rdata
);
	reg [7:0] mem [0:(1<<AW)-1];
	always @(posedge sys_clk)
	begin
		if (we)
			mem[addr] <= wdata;
		rdata <= mem[addr];
	end
endmodule // mmdec_ram
`default_nettype wire

// [verilog/mmdec_top.v]
// Purpose: decode register file and program memory accesses of an 8-bit core
// Assumes: flash and control registers sit outside; answers one cycle after a request
// Notes: info area is a read-only array loaded on a separate load port
`include "mmdec_defs.vh"
`default_nettype none
module mmdec_top #(
	parameter FLASH_BYTES = 17'h02000,
	parameter RAM_AW = 8
) (
	input wire sys_clk,
	input wire rst,
	input wire rf_req,
	input wire rf_we,
	input wire [11:0] rf_addr,
	input wire [7:0] rf_wdata,
	output reg [7:0] rf_rdata,
	output reg rf_ack,
	output reg ctl_sel,
	output reg ctl_we,
	output reg [7:0] ctl_addr,
	output reg [7:0] ctl_wdata,
	input wire [7:0] ctl_rdata,
	input wire pm_req,
	input wire pm_we,
	input wire [15:0] pm_addr,
	input wire [7:0] pm_wdata,
	input wire [7:0] page_select,
	output reg [7:0] pm_rdata,
	output reg pm_ack,
	output reg [1:0] pm_region,
	output reg flash_sel,
	output reg flash_we,
	output reg [15:0] flash_addr,
	output reg [7:0] flash_wdata,
	input wire [7:0] flash_rdata,
	input wire dm_req,
	output reg [7:0] dm_rdata,
	output reg dm_ack,
	input wire info_load,
	input wire [6:0] info_load_addr,
	input wire [7:0] info_load_data
);
	reg [7:0] info_mem [0:127];
	reg [1:0] rf_kind_reg;
	reg [1:0] rf_kind_next;
	reg [1:0] pm_kind_reg;
	reg [1:0] pm_kind_next;
	reg rf_rd_reg;
	reg pm_rd_reg;
	reg [7:0] info_q_reg;
	wire [7:0] ram_q;
	wire rf_is_ctl = rf_addr >= `MMDEC_RF_CTL_BASE;
	wire rf_is_ram = rf_addr <= `MMDEC_RAM_TOP;
	wire pm_in_flash = {1'b0, pm_addr} < FLASH_BYTES[16:0];
	wire info_en = page_select[`MMDEC_INFO_EN_BIT];
	wire pm_in_info = info_en && pm_addr >= `MMDEC_INFO_BASE && pm_addr <= `MMDEC_INFO_LAST;
	localparam K_CTL = 2'h0;
	localparam K_RAM = 2'h1;
	localparam K_NONE = 2'h2;
	localparam K_INFO = 2'h3;
	localparam K_FLASH = 2'h0;

	always @*
	begin
		if (rf_is_ctl)
			rf_kind_next = K_CTL;
		else if (rf_is_ram)
			rf_kind_next = K_RAM;
		else
			rf_kind_next = K_NONE;
	end

	// Overlay first, so info data shadows any flash behind it
	always @*
	begin
		if (pm_in_info)
			pm_kind_next = K_INFO;
		else if (pm_in_flash)
			pm_kind_next = K_FLASH;
		else
			pm_kind_next = K_NONE;
	end

	mmdec_ram #(.AW(RAM_AW)) u_ram (
		.sys_clk(sys_clk),
		.we(rf_req && rf_we && rf_kind_next == K_RAM),
		.addr(rf_addr[RAM_AW-1:0]),
		.wdata(rf_wdata),
		.rdata(ram_q)
	);

	// Load port only; the core path has no write into this array
	always @(posedge sys_clk)
	begin
		if (info_load)
			info_mem[info_load_addr] <= info_load_data;
		info_q_reg <= info_mem[pm_addr[6:0]];
	end

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			ctl_sel <= 1'b0;
			ctl_we <= 1'b0;
			ctl_addr <= 8'h00;
			ctl_wdata <= 8'h00;
			rf_ack <= 1'b0;
			rf_kind_reg <= K_NONE;
			rf_rd_reg <= 1'b0;
		end
		else
		begin
			// Reserved control writes pass through; outcome belongs to the peripheral
			ctl_sel <= rf_req && rf_kind_next == K_CTL;
			ctl_we <= rf_req && rf_we && rf_kind_next == K_CTL;
			ctl_addr <= rf_addr[7:0];
			ctl_wdata <= rf_wdata;
			rf_ack <= rf_req;
			rf_kind_reg <= rf_kind_next;
			rf_rd_reg <= rf_req && !rf_we;
		end
	end

	// Read data shows one cycle after ack; control data is the peripheral's answer
	always @(posedge sys_clk)
	begin
		if (rst)
			rf_rdata <= 8'h00;
		// Writes leave the last read data standing
		else if (rf_ack && rf_rd_reg)
		begin
			case (rf_kind_reg)
				K_CTL: rf_rdata <= ctl_rdata;
				K_RAM: rf_rdata <= ram_q;
				K_NONE: rf_rdata <= `MMDEC_RF_UNDEF;
				default: rf_rdata <= `MMDEC_RF_UNDEF;
			endcase
		end
	end

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			flash_sel <= 1'b0;
			flash_we <= 1'b0;
			flash_addr <= 16'h0000;
			flash_wdata <= 8'h00;
			pm_ack <= 1'b0;
			pm_kind_reg <= K_NONE;
			pm_rd_reg <= 1'b0;
			pm_region <= `MMDEC_REGION_OPT;
		end
		else
		begin
			flash_sel <= pm_req && pm_in_flash && !pm_in_info;
			flash_we <= pm_req && pm_we && pm_in_flash && !pm_in_info;
			flash_addr <= pm_addr;
			flash_wdata <= pm_wdata;
			pm_ack <= pm_req;
			pm_kind_reg <= pm_kind_next;
			pm_rd_reg <= pm_req && !pm_we;
			if (pm_addr <= `MMDEC_OPT_LAST)
				pm_region <= `MMDEC_REGION_OPT;
			else if (pm_addr <= `MMDEC_RSTV_LAST)
				pm_region <= `MMDEC_REGION_RSTV;
			else if (pm_addr <= `MMDEC_IVEC_LAST)
				pm_region <= `MMDEC_REGION_IVEC;
			else
				pm_region <= `MMDEC_REGION_CODE;
		end
	end

	always @(posedge sys_clk)
	begin
		if (rst)
			pm_rdata <= 8'h00;
		else if (pm_ack && pm_rd_reg)
		begin
			case (pm_kind_reg)
				K_INFO: pm_rdata <= info_q_reg;
				K_FLASH: pm_rdata <= flash_rdata;
				K_NONE: pm_rdata <= `MMDEC_PM_ABSENT;
				default: pm_rdata <= `MMDEC_PM_ABSENT;
			endcase
		end
	end

	// No storage behind data space; answer only so the core never hangs
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			dm_ack <= 1'b0;
			dm_rdata <= 8'h00;
		end
		else
		begin
			dm_ack <= dm_req;
			dm_rdata <= `MMDEC_PM_ABSENT;
		end
	end
endmodule // mmdec_top
`default_nettype wire

// [bench/mmdec_far.sv]
// Purpose: flash and peripheral model
// Assumes: answers while selected
// Notes: unselected buses show inverted address
`default_nettype none
module mmdec_far (
	input wire logic [7:0] ctl_addr,
	input wire logic ctl_sel,
	input wire logic [15:0] flash_addr,
	input wire logic flash_sel,
	output logic [7:0] ctl_rdata,
	output logic [7:0] flash_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	assign ctl_rdata = ctl_sel ? ctl_addr ^ 8'hC3 : ~ctl_addr;
	assign flash_rdata = flash_sel ? flash_addr[7:0] ^ 8'hA5 : ~flash_addr[7:0];
endmodule // mmdec_far
`default_nettype wire

// [bench/mmdec_properties.sv]
// Purpose: decoder port properties
// Assumes: one clock domain
// Notes: bound below
`default_nettype none
module mmdec_props #(parameter FLASH_BYTES = 17'h02000) (input wire sys_clk, rst, rf_req, rf_we, rf_ack, ctl_sel,
	pm_req, pm_we, flash_we, dm_req, dm_ack, input wire [11:0] rf_addr, input wire [15:0] pm_addr,
	input wire [7:0] rf_rdata, ctl_addr, pm_rdata, dm_rdata, page_select, input wire [1:0] pm_region);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire ctl = rf_addr[11:8] == 4'hF;
	wire ovl = page_select[7] && pm_addr[15:7] == 9'h1FC;
	a_rf_ack: assert property (rf_req |=> rf_ack) else $error("no ack");
	a_ctl_sel: assert property (rf_req && ctl |=> ctl_sel && ctl_addr == $past(rf_addr[7:0])) else $error("ctl");
	a_ctl_only: assert property (rf_req && !ctl |=> !ctl_sel) else $error("stray ctl");
	a_gap_read: assert property (rf_req && !rf_we && !ctl && rf_addr[11:8] != 0 |=> ##1 rf_rdata == 8'h00)
		else $error("gap");
	a_pm_absent: assert property (pm_req && !pm_we && !ovl && pm_addr >= FLASH_BYTES |=> ##1 pm_rdata == 8'hFF)
		else $error("absent");
	a_pm_drop: assert property (pm_req && pm_we && (ovl || pm_addr >= FLASH_BYTES) |=> !flash_we)
		else $error("write");
	a_dm_none: assert property (dm_req |=> dm_ack ##1 dm_rdata == 8'hFF) else $error("dm");
	a_vec_region: assert property (pm_req && pm_addr[15:2] == 0 |=> pm_region == {1'b0, $past(pm_addr[1])})
		else $error("region");
endmodule // mmdec_props
bind mmdec_top mmdec_props #(.FLASH_BYTES(FLASH_BYTES)) mmdec_props_i (.*);
`default_nettype wire

// [bench/test_memory_map_decoder.sv]
// Purpose: decoder bench
// Assumes: two-cycle read latency
// Notes: one control write, to F00
`default_nettype none
module test_memory_map_decoder;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; $display("CHECK FAILED %0t %h %h", $time, a, b); end end
	logic sys_clk = 0, rst = 1, rf_req = 0, rf_we = 0, pm_req = 0, pm_we = 0, dm_req = 0, info_load = 0;
	logic [11:0] rf_addr = 0;
	logic [15:0] pm_addr = 0;
	logic [7:0] rf_wdata = 0, pm_wdata = 0, page_select = 0, info_load_data = 0;
	logic [6:0] info_load_addr = 0;
	wire [7:0] rf_rdata, ctl_addr, ctl_wdata, ctl_rdata, pm_rdata, flash_wdata, flash_rdata, dm_rdata;
	wire [15:0] flash_addr;
	wire [1:0] pm_region;
	wire rf_ack, ctl_sel, ctl_we, pm_ack, flash_sel, flash_we, dm_ack;
	int num_errors = 0, num_checks = 0;
	always #25 sys_clk = ~sys_clk;
	mmdec_top mmdec_top_i (.*);
	mmdec_far mmdec_far_i (.*);
	task rf(input logic w, input logic [11:0] a, input logic [7:0] d, e);
		@(negedge sys_clk) {rf_req, rf_we, rf_addr, rf_wdata} = {1'b1, w, a, d};
		@(negedge sys_clk) rf_req = 0;
		`CHK(rf_ack, 1'b1)
		`CHK(ctl_sel, a[11:8] == 4'hF)
		`CHK(ctl_we, w && a[11:8] == 4'hF)
		`CHK(ctl_addr, a[7:0])
		`CHK(ctl_wdata, d)
		@(negedge sys_clk) if (!w) `CHK(rf_rdata, e)
	endtask
	task pm(input logic w, input logic [15:0] a, input logic [7:0] d, e);
		logic fl;
		logic [1:0] rg;
		// Default flash is 8 KB; the overlay hides flash from the core
		fl = a < 16'h2000 && !(page_select[7] && a[15:7] == 9'h1FC);
		rg = a <= 16'h0001 ? 2'h0 : a <= 16'h0003 ? 2'h1 : a <= 16'h003D ? 2'h2 : 2'h3;
		@(negedge sys_clk) {pm_req, pm_we, pm_addr, pm_wdata} = {1'b1, w, a, d};
		@(negedge sys_clk) pm_req = 0;
		`CHK(pm_ack, 1'b1)
		`CHK(flash_sel, fl)
		`CHK(flash_we, w && fl)
		`CHK(flash_addr, a)
		`CHK(flash_wdata, d)
		`CHK(pm_region, rg)
		@(negedge sys_clk) if (!w) `CHK(pm_rdata, e)
	endtask
	task t_ram;
		rf(1, 12'h000, 8'h5A, 0);
		rf(1, 12'h0FF, 8'hA5, 0);
		rf(0, 12'h000, 0, 8'h5A);
		rf(0, 12'h0FF, 0, 8'hA5);
	endtask
	task t_gap;
		// Write at 100 must not wrap onto 000
		rf(1, 12'h100, 8'h77, 0);
		rf(0, 12'hEFF, 0, 8'h00);
		rf(0, 12'h000, 0, 8'h5A);
	endtask
	task t_ctl;
		rf(0, 12'hF05, 0, 8'hC6);
		rf(0, 12'hFFF, 0, 8'h3C);
		// Writes go only to an implemented register
		rf(1, 12'hF00, 8'h3E, 0);
	endtask
	task t_pm;
		pm(0, 16'h0003, 0, 8'hA6);
		pm(0, 16'h0000, 0, 8'hA5);
		pm(0, 16'h0004, 0, 8'hA1);
		pm(0, 16'h1FFF, 0, 8'h5A);
		pm(1, 16'h2000, 8'h12, 0);
		pm(0, 16'h2000, 0, 8'hFF);
	endtask
	task t_info;
		@(negedge sys_clk) {info_load, info_load_addr, info_load_data} = {1'b1, 7'h41, 8'h9B};
		@(negedge sys_clk) {info_load, page_select} = {1'b0, 8'h80};
		pm(0, 16'hFE41, 0, 8'h9B);
		pm(1, 16'hFE41, 8'h00, 0);
		pm(0, 16'hFE41, 0, 8'h9B);
		page_select = 0;
		pm(0, 16'hFE41, 0, 8'hFF);
	endtask
	task t_dm;
		@(negedge sys_clk) dm_req = 1;
		@(negedge sys_clk) dm_req = 0;
		`CHK(dm_ack, 1'b1)
		@(negedge sys_clk) `CHK(dm_rdata, 8'hFF)
	endtask
	task report_and_stop;
		$display("errors %0d checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(negedge sys_clk);
		rst = 0;
		t_ram;
		t_gap;
		t_ctl;
		t_pm;
		t_info;
		t_dm;
		report_and_stop;
	end
	// Run needs about 4 us
	initial
	begin
		#100000;
		num_errors++;
		report_and_stop;
	end
endmodule // test_memory_map_decoder
`default_nettype wire
